// File: verilog/pirq_pkg.sv
// Package: register map, field positions and reset values of the flag block
package pirq_pkg;

    // ********************************************
    // Register byte addresses (one word each)
    // ********************************************
    localparam logic [7:0] ADDR_FLAGS = 8'h16;    // Request flags (bank 1)
    localparam logic [7:0] ADDR_ENABLE = 8'h17;   // Peripheral enables
    localparam logic [7:0] ADDR_CORE = 8'h18;     // Core status (disable)
    localparam logic [7:0] ADDR_TCFG = 8'h1C;     // Timer configuration
    localparam logic [7:0] ADDR_P1 = 8'h20;       // First period
    localparam logic [7:0] ADDR_P2 = 8'h24;       // Second period
    localparam logic [7:0] ADDR_P3 = 8'h28;       // Third period pair
    localparam logic [7:0] ADDR_PMATCH = 8'h2C;   // Port change latch
    localparam logic [7:0] ADDR_CNT = 8'h30;      // Timer counts

    // ********************************************
    // Flag bit positions
    // ********************************************
    localparam int BIT_PORT = 7;
    localparam int BIT_T3 = 6;
    localparam int BIT_T2 = 5;
    localparam int BIT_T1 = 4;
    localparam int BIT_CAP2 = 3;
    localparam int BIT_CAP1 = 2;
    localparam int BIT_TX = 1;
    localparam int BIT_RX = 0;
    localparam int BIT_GDIS = 4;      // Disable bit in core status
    localparam int BIT_WIDTH = 0;     // Timer width select in config
    localparam int BIT_CAPSEL = 1;    // Capture or period select
    localparam int BIT_TRUN = 2;      // Timer run enable

    // ********************************************
    // Reset values and masks
    // ********************************************
    localparam logic [7:0] RW_FLAG_MASK = 8'hFC;   // Bits 7..2 writable
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] CORE_RESET = 8'h10;     // Disable set by reset
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage

// File: verilog/pirq_timer8.sv
// Module: 8-bit period timer with roll-to-zero pulse
`timescale 1ns/10ps
module pirq_timer8
    import pirq_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Control
    input wire logic tick,
    input wire logic [7:0] period,
    // Count and event
    output logic [7:0] count,
    output logic match,
    output logic rolled
);

    // ********************************************
    // State
    // ********************************************
    typedef struct packed {
        logic [7:0] cnt;    // Running count
        logic roll;         // One-cycle roll pulse
    } t8_state_t;

    t8_state_t st;        // Registered state
    t8_state_t next_st;   // Next state

    assign match = (st.cnt == period);
    assign count = st.cnt;
    assign rolled = st.roll;

    // Count up, wrap to zero on period match
    always_comb begin
        next_st = st;
        next_st.roll = 1'b0;
        if (tick) begin
            if (match) begin
                next_st.cnt = ZERO16[7:0];
                next_st.roll = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// File: verilog/pirq_sync.sv
// Module: two-flop synchroniser with rising edge detect, per bit
`timescale 1ns/10ps
module pirq_sync #(
    parameter int W = 10
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Asynchronous input and synced results
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);

    // ********************************************
    // State
    // ********************************************
    typedef struct packed {
        logic [W-1:0] s1;    // First flop, read only by s2
        logic [W-1:0] s2;    // Synced level
        logic [W-1:0] s3;    // Delayed copy for edges
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    assign level = st.s2;

    // Edge detect uses only the second and third flops
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_edge
            assign rise[i] = st.s2[i] & ~st.s3[i];
        end
    endgenerate

    // Shift chain
    always_comb begin
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    // State register
    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// File: verilog/peripheral_irq_flags.sv
// Module: peripheral request flags, enables and combined request
// Operation
// - Flags set regardless of enable or disable
// - Flag register at address 16h
// - Port mismatch sets bit 7 continuously
// - Capture mode: third timer overflow sets 6
// - Period mode: third timer period roll sets 6
// - 8-bit mode: second timer period roll sets bit 5
// - 8-bit mode: first timer roll sets 4
// - 16-bit mode: paired timers roll sets 4
// - Second capture pin edge sets bit 3
// - First capture pin edge sets bit 2
// - Bit 1 reads transmit buffer empty
// - Bit 0 reads receive buffer full
// - Enable bit 1 gates transmit interrupt
// - Enable bit 0 gates receive interrupt
// - Combined request is OR of flag&enable
// - Global disable set by reset, blocks
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/10ps
module peripheral_irq_flags
    import pirq_pkg::*;
#(
    parameter int PORT_W = 8    // Monitored port width
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Avalon-MM slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // External pins
    input wire logic [PORT_W-1:0] CHANGE_MONITOR_PORT,
    input wire logic FIRST_CAPTURE_PIN,
    input wire logic SECOND_CAPTURE_PIN,
    // Transceiver buffer status (same clock)
    input wire logic TX_BUF_EMPTY,
    input wire logic RX_BUF_FULL,
    // Requests to the core
    output logic COMBINED_PERIPHERAL_REQUEST,
    output logic IRQ
);

    // ********************************************
    // Types and state
    // ********************************************
    typedef struct packed {
        logic [7:2] flags;            // Sticky request flags
        logic [7:0] enable;           // Peripheral enable reg
        logic [7:0] core_status;      // Holds global disable
        logic [7:0] cfg;              // Width, select, run
        logic [7:0] first_period_reg;
        logic [7:0] second_period_reg;
        logic [7:0] third_period_low;
        logic [7:0] third_period_high;
        logic [15:0] third_timer_count;
        logic [PORT_W-1:0] port_latch; // Latched port value
        logic [31:0] rdata;           // Registered read data
        logic ack;                    // Answer pulse
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    // Synchroniser outputs
    logic [PORT_W+1:0] sync_level;
    logic [PORT_W+1:0] sync_rise;
    // Timer wires
    logic [7:0] t1_count;
    logic [7:0] t2_count;
    logic t1_match;
    logic t2_match;
    logic t1_roll;
    logic t2_roll;
    logic t2_tick;
    logic run;
    logic wide;
    logic cap_mode;
    logic [15:0] third_period;
    logic t3_match;
    logic t3_roll;
    logic wide_roll;
    logic [7:0] t1_period;        // Low half wraps at all ones when paired, until high half matches
    logic [7:0] flag_view;        // Full flag register as read
    logic [7:0] src_set;          // Hardware set terms
    logic port_mismatch;
    logic [7:0] wmask;            // Write bits with byte lane 0
    logic sel_wr;
    logic sel_rd;

    assign run = st.cfg[BIT_TRUN];
    assign wide = st.cfg[BIT_WIDTH];
    assign cap_mode = st.cfg[BIT_CAPSEL];
    assign third_period = {st.third_period_high, st.third_period_low};

    // ********************************************
    // Pin synchronisers
    // ********************************************
    pirq_sync #(
        .W(PORT_W + 2)
    ) u_sync (
        .CLK(CLK),
        .RST(RST),
        .async_in({CHANGE_MONITOR_PORT, SECOND_CAPTURE_PIN,
                   FIRST_CAPTURE_PIN}),
        .level(sync_level),
        .rise(sync_rise)
    );

    // ********************************************
    // First and second timers
    // ********************************************
    // In wide mode the first timer carries into the second
    // low half only wraps at its period when high half matches
    assign t1_period = (wide & ~t2_match) ? 8'hFF : st.first_period_reg;

    pirq_timer8 u_t1 (
        .CLK(CLK),
        .RST(RST),
        .tick(run),
        .period(t1_period),
        .count(t1_count),
        .match(t1_match),
        .rolled(t1_roll)
    );

    // Second timer ticks on each first-timer roll when paired
    assign t2_tick = wide ? (run & t1_match) : run;

    pirq_timer8 u_t2 (
        .CLK(CLK),
        .RST(RST),
        .tick(t2_tick),
        .period(st.second_period_reg),
        .count(t2_count),
        .match(t2_match),
        .rolled(t2_roll)
    );

    // Paired roll: both halves wrapped together
    assign wide_roll = t1_roll & t2_roll;

    // Third timer: overflow in capture mode, period roll otherwise
    assign t3_match = cap_mode ? (st.third_timer_count == 16'hFFFF)
                               : (st.third_timer_count == third_period);
    assign t3_roll = run & t3_match;

    // Port mismatch against latched value
    assign port_mismatch = (sync_level[PORT_W+1:2] != st.port_latch);

    // ********************************************
    // Flag sources
    // ********************************************
    always_comb begin
        src_set = 8'h00;
        src_set[BIT_PORT] = port_mismatch;
        src_set[BIT_T3] = t3_roll;
        src_set[BIT_T2] = t2_roll & ~wide;
        src_set[BIT_T1] = wide ? wide_roll : t1_roll;
        src_set[BIT_CAP2] = sync_rise[1];
        src_set[BIT_CAP1] = sync_rise[0];
    end

    assign flag_view = {st.flags, TX_BUF_EMPTY, RX_BUF_FULL};

    // ********************************************
    // Bus decode
    // ********************************************
    assign wmask = AVS_BYTEENABLE[0] ? 8'hFF : 8'h00;
    // Writes land on the answer edge, when waitrequest is seen low
    assign sel_wr = AVS_WRITE & st.ack;
    assign sel_rd = AVS_READ & ~st.ack;
    // Wait one cycle, then answer on the ack cycle
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~st.ack;
    assign AVS_READDATA = st.rdata;

    assign COMBINED_PERIPHERAL_REQUEST = |(flag_view & st.enable);
    // global disable blocks the request to the core
    assign IRQ = COMBINED_PERIPHERAL_REQUEST & ~st.core_status[BIT_GDIS];

    // ********************************************
    // Next-state logic
    // ********************************************
    always_comb begin
        next_st = st;
        next_st.ack = (AVS_WRITE | AVS_READ) & ~st.ack;
        // Third timer count
        if (run) begin
            next_st.third_timer_count = t3_match ? ZERO16
                : st.third_timer_count + 16'h0001;
        end
        // Register writes
        if (sel_wr) begin
            unique case (AVS_ADDRESS)
                ADDR_FLAGS: next_st.flags =
                    (AVS_WRITEDATA[7:2] & RW_FLAG_MASK[7:2] & wmask[7:2])
                    | (st.flags & ~wmask[7:2]);
                ADDR_ENABLE: next_st.enable = AVS_WRITEDATA[7:0] & wmask
                    | st.enable & ~wmask;
                ADDR_CORE: next_st.core_status = AVS_WRITEDATA[7:0] & wmask
                    | st.core_status & ~wmask;
                ADDR_TCFG: next_st.cfg = AVS_WRITEDATA[7:0] & wmask
                    | st.cfg & ~wmask;
                ADDR_P1: next_st.first_period_reg = AVS_WRITEDATA[7:0];
                ADDR_P2: next_st.second_period_reg = AVS_WRITEDATA[7:0];
                ADDR_P3: begin
                    next_st.third_period_low = AVS_WRITEDATA[7:0];
                    next_st.third_period_high = AVS_WRITEDATA[15:8];
                end
                // Writing here re-latches the port, ending mismatch
                ADDR_PMATCH: next_st.port_latch = sync_level[PORT_W+1:2];
                default: ;
            endcase
        end
        // hardware set after write, so set wins
        next_st.flags = next_st.flags | src_set[7:2];
        // Read data
        if (sel_rd) begin
            unique case (AVS_ADDRESS)
                ADDR_FLAGS: next_st.rdata = {24'h00_0000, flag_view};
                ADDR_ENABLE: next_st.rdata = {24'h00_0000, st.enable};
                ADDR_CORE: next_st.rdata = {24'h00_0000, st.core_status};
                ADDR_TCFG: next_st.rdata = {24'h00_0000, st.cfg};
                ADDR_P1: next_st.rdata = {24'h00_0000, st.first_period_reg};
                ADDR_P2: next_st.rdata = {24'h00_0000, st.second_period_reg};
                ADDR_P3: next_st.rdata = {16'h0000, third_period};
                ADDR_PMATCH: next_st.rdata =
                    32'(st.port_latch);
                ADDR_CNT: next_st.rdata = {t2_count, t1_count,
                    st.third_timer_count};
                default: next_st.rdata = UNMAPPED_READ;
            endcase
        end
    end

    // ********************************************
    // State register
    // ********************************************
    // reset values
    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
            st.enable <= ENABLE_RESET;
            st.core_status <= CORE_RESET;
            st.cfg <= CFG_RESET;
            st.first_period_reg <= PERIOD_RESET;
            st.second_period_reg <= PERIOD_RESET;
            st.third_period_low <= PERIOD_RESET;
            st.third_period_high <= PERIOD_RESET;
        end else begin
            st <= next_st;
        end
    end

endmodule

// File: tb/pirq_checker.sv
// Checker: bus timing and request gating at the flag block ports
`timescale 1ns/10ps
module pirq_checker
    import pirq_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register bus
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // Buffer levels and requests
    input wire logic TX_BUF_EMPTY,
    input wire logic RX_BUF_FULL,
    input wire logic COMBINED_PERIPHERAL_REQUEST,
    input wire logic IRQ
);
    // ****************
    // Shared sequences
    // ****************
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Read answered at this edge
    sequence rd_done(logic [7:0] a);
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == a;
    endsequence
    // Core status write taken, disable bit value v
    sequence core_wr(logic v);
        AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
            && AVS_ADDRESS == ADDR_CORE && AVS_WRITEDATA[BIT_GDIS] == v;
    endsequence
    // ****************
    // Assertions
    // ****************
    a_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST) else $error("bus answer late");
    a_unmapped_zero: assert property (rd_done(8'h40)
        |-> AVS_READDATA == 32'h0000_0000) else $error("unmapped read");
    a_flag_width: assert property (rd_done(ADDR_FLAGS)
        |-> AVS_READDATA[31:8] == 24'h00_0000) else $error("flag width");
    a_tx_live: assert property (rd_done(ADDR_FLAGS) ##0 $stable(TX_BUF_EMPTY)
        |-> AVS_READDATA[1] == TX_BUF_EMPTY) else $error("tx flag");
    a_rx_live: assert property (rd_done(ADDR_FLAGS) ##0 $stable(RX_BUF_FULL)
        |-> AVS_READDATA[0] == RX_BUF_FULL) else $error("rx flag");
    a_irq_needs_req: assert property (IRQ
        |-> COMBINED_PERIPHERAL_REQUEST) else $error("irq without request");
    a_quiet_reset: assert property ($past(RST)
        |-> !IRQ && !COMBINED_PERIPHERAL_REQUEST) else $error("reset level");
    a_core_open: assert property (core_wr(1'b0)
        |=> IRQ == COMBINED_PERIPHERAL_REQUEST) else $error("irq not passed");
    a_core_shut: assert property (core_wr(1'b1)
        |=> !IRQ [*2]) else $error("irq not blocked");
endmodule

bind peripheral_irq_flags pirq_checker u_checker (.CLK(CLK), .RST(RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .TX_BUF_EMPTY(TX_BUF_EMPTY), .RX_BUF_FULL(RX_BUF_FULL),
    .COMBINED_PERIPHERAL_REQUEST(COMBINED_PERIPHERAL_REQUEST), .IRQ(IRQ));

// File: tb/pirq_xcvr_model.sv
// Model: serial transceiver buffer levels seen by the flag block
`timescale 1ns/10ps
module pirq_xcvr_model #(
    parameter int SHIFT_CYCLES = 12   // Frame time, kept short
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Commands from the bench
    input wire logic tx_load,
    input wire logic rx_arrive,
    input wire logic rx_take,
    // Buffer levels
    output logic tx_empty,
    output logic rx_full
);
    int left;   // Cycles until holding buffer drains
    // Holding buffer empties once the frame has shifted out
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_empty <= 1'b1;
            rx_full <= 1'b0;
            left <= 0;
        end else begin
            if (tx_load) begin
                tx_empty <= 1'b0;
                left <= SHIFT_CYCLES;
            end else if (left == 1) begin
                tx_empty <= 1'b1;
                left <= 0;
            end else if (left > 1) begin
                left <= left - 1;
            end
            // Arrival wins over a read in the same cycle
            if (rx_arrive) begin
                rx_full <= 1'b1;
            end else if (rx_take) begin
                rx_full <= 1'b0;
            end
        end
    end
endmodule

// File: tb/peripheral_irq_flags_test.sv
// Testbench: flag block scenarios over the register bus
`timescale 1ns/10ps
module peripheral_irq_flags_test;
    import pirq_pkg::*;
    logic clk, rst, read, write, waitreq, comb, irq, cap1, cap2;
    logic tx_load, rx_arrive, rx_take, tx_empty, rx_full;
    logic [7:0] address, port;
    logic [31:0] writedata, readdata;
    int fail_count = 0;
    int checked = 0;
    // ****************
    // Clock and instances
    // ****************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    peripheral_irq_flags DUT (.CLK(clk), .RST(rst), .AVS_ADDRESS(address),
        .AVS_READ(read), .AVS_WRITE(write), .AVS_WRITEDATA(writedata),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(readdata),
        .AVS_WAITREQUEST(waitreq), .CHANGE_MONITOR_PORT(port),
        .FIRST_CAPTURE_PIN(cap1), .SECOND_CAPTURE_PIN(cap2),
        .TX_BUF_EMPTY(tx_empty), .RX_BUF_FULL(rx_full),
        .COMBINED_PERIPHERAL_REQUEST(comb), .IRQ(irq));
    pirq_xcvr_model u_xcvr (.clk(clk), .rst(rst), .tx_load(tx_load),
        .rx_arrive(rx_arrive), .rx_take(rx_take), .tx_empty(tx_empty),
        .rx_full(rx_full));
    // ****************
    // Shared tasks
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hold the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                fail_count++;
                $display("[ERR] %0t bus hang", $time);
                final_report();
            end
        end while (waitreq !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q, exp);
    endtask
    task automatic lv(input int n, input logic [1:0] exp);
        repeat (n) @(posedge clk);
        @(negedge clk);
        check({30'h0, irq, comb}, {30'h0, exp});
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset_access;
        rd(ADDR_FLAGS, 32'h0000_0002);
        rd(ADDR_CORE, 32'h0000_0010);
        rd(8'h40, 32'h0000_0000);
        wr(ADDR_FLAGS, 32'h0000_00FF);
        rd(ADDR_FLAGS, 32'h0000_00FE);
        wr(ADDR_FLAGS, 32'h0000_0000);
        rd(ADDR_FLAGS, 32'h0000_0002);
    endtask
    task automatic t_timers;
        wr(ADDR_P1, 32'h0000_0005);
        wr(ADDR_P2, 32'h0000_0005);
        wr(ADDR_P3, 32'h0000_0006);
        wr(ADDR_TCFG, 32'h0000_0004);
        repeat (30) @(posedge clk);
        rd(ADDR_FLAGS, 32'h0000_0072);
        wr(ADDR_TCFG, 32'h0000_0005);
        wr(ADDR_FLAGS, 32'h0000_0000);
        repeat (1300) @(posedge clk);
        rd(ADDR_FLAGS, 32'h0000_0052);
        wr(ADDR_TCFG, 32'h0000_0006);
        wr(ADDR_FLAGS, 32'h0000_0000);
        repeat (300) @(posedge clk);
        rd(ADDR_FLAGS, 32'h0000_0032);
        repeat (65540) @(posedge clk);
        rd(ADDR_FLAGS, 32'h0000_0072);
        wr(ADDR_TCFG, 32'h0000_0000);
        wr(ADDR_FLAGS, 32'h0000_0000);
        rd(ADDR_FLAGS, 32'h0000_0002);
    endtask
    task automatic t_capture;
        cap1 <= 1'b1;
        lv(4, 2'b00);
        cap1 <= 1'b0;
        rd(ADDR_FLAGS, 32'h0000_0006);
        cap2 <= 1'b1;
        lv(4, 2'b00);
        cap2 <= 1'b0;
        rd(ADDR_FLAGS, 32'h0000_000E);
        wr(ADDR_FLAGS, 32'h0000_0000);
        rd(ADDR_FLAGS, 32'h0000_0002);
    endtask
    task automatic t_port;
        wr(ADDR_PMATCH, 32'h0000_0000);
        port <= 8'h01;
        lv(4, 2'b00);
        wr(ADDR_FLAGS, 32'h0000_0000);
        rd(ADDR_FLAGS, 32'h0000_0082);
        port <= 8'h00;
        lv(4, 2'b00);
        wr(ADDR_FLAGS, 32'h0000_0000);
        rd(ADDR_FLAGS, 32'h0000_0002);
    endtask
    task automatic t_irq;
        wr(ADDR_FLAGS, 32'h0000_0000);
        wr(ADDR_ENABLE, 32'h0000_0003);
        lv(1, 2'b01);
        wr(ADDR_CORE, 32'h0000_0000);
        lv(1, 2'b11);
        tx_load <= 1'b1;
        @(posedge clk);
        tx_load <= 1'b0;
        lv(1, 2'b00);
        rx_arrive <= 1'b1;
        @(posedge clk);
        rx_arrive <= 1'b0;
        lv(1, 2'b11);
        wr(ADDR_ENABLE, 32'h0000_0002);
        lv(1, 2'b00);
        rx_take <= 1'b1;
        @(posedge clk);
        rx_take <= 1'b0;
        lv(14, 2'b11);
        wr(ADDR_CORE, 32'h0000_0010);
        lv(1, 2'b01);
        wr(ADDR_ENABLE, 32'h0000_0000);
        lv(1, 2'b00);
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0000_0000;
        port = 8'h00;
        cap1 = 1'b0;
        cap2 = 1'b0;
        tx_load = 1'b0;
        rx_arrive = 1'b0;
        rx_take = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset_access();
        t_timers();
        t_capture();
        t_port();
        t_irq();
        final_report();
    end
endmodule
